//--- inc/ssf_pkg.sv
package ssf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map and bus layout
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] STATUS_WORD_OFFSET = 8'h64;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Status word field positions
    localparam int CMD_ERR_BIT = 10;
    localparam int LOOP_ERR_BIT = 9;
    localparam int MSB_ERR_BIT = 8;
    localparam int ROLE_ERR_BIT = 7;
    localparam int CLK_ERR_BIT = 6;
    localparam int FLAG_LSB = CLK_ERR_BIT;
    localparam int FLAG_MSB = CMD_ERR_BIT;

    ////////////////////////////////////////////////////////////////////////////////
    // Build-time transfer mode
    localparam logic [1:0] MODE_STANDARD = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_QUAD = 2'h2;

    // Line count of a command, address or data phase
    localparam logic [1:0] LINES_SINGLE = 2'h0;

    // Memory families with different command lists
    localparam logic [1:0] MEM_FAMILY_A = 2'h0;
    localparam logic [1:0] MEM_FAMILY_B = 2'h1;
    localparam logic [1:0] MEM_FAMILY_C = 2'h2;
    localparam logic [1:0] MEM_FAMILY_D = 2'h3;

    // Command codes accepted as the first transmit queue word
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_DUAL_READ = 8'h3B;
    localparam logic [7:0] CMD_QUAD_READ = 8'h6B;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_READ_ID = 8'h9F;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] CMD_QUAD_PROGRAM = 8'h32;
    localparam logic [7:0] CMD_FAMILY_EXTRA = 8'h38;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers

    // Fields of the control word that the error flags look at
    typedef struct packed {
        logic [1:0] cmd_lines;
        logic [1:0] addr_lines;
        logic [1:0] data_lines;
        logic lsb_first;
        logic controller_role;
        logic clk_polarity;
        logic clk_phase;
        logic loop_back;
    } ssf_ctrl_t;

    // Same order as status bits 10 down to 6
    typedef struct packed {
        logic cmd_err;
        logic loop_err;
        logic msb_err;
        logic role_err;
        logic clk_err;
    } ssf_flags_t;

    localparam ssf_flags_t FLAGS_RESET = '{cmd_err: 1'b0, loop_err: 1'b0, msb_err: 1'b0,
                                           role_err: 1'b1, clk_err: 1'b0};

endpackage : ssf_pkg

//--- src/ssf_cmd_check.sv
`timescale 1ns/10ps
// Looks up a command byte in the list of the chosen memory family.
module ssf_cmd_check (
    input wire logic [1:0] mem_family,
    input wire logic [7:0] cmd,
    output logic supported
);

    logic common_ok;
    logic family_ok;

    always_comb begin
        case (cmd)
            ssf_pkg::CMD_READ,
            ssf_pkg::CMD_FAST_READ,
            ssf_pkg::CMD_DUAL_READ,
            ssf_pkg::CMD_QUAD_READ,
            ssf_pkg::CMD_WRITE_ENABLE,
            ssf_pkg::CMD_PAGE_PROGRAM,
            ssf_pkg::CMD_READ_STATUS,
            ssf_pkg::CMD_READ_ID,
            ssf_pkg::CMD_SECTOR_ERASE: common_ok = 1'b1;
            default: common_ok = 1'b0;
        endcase
    end

    // Families differ only in their quad program opcode
    always_comb begin
        case (mem_family)
            ssf_pkg::MEM_FAMILY_A,
            ssf_pkg::MEM_FAMILY_C: family_ok = (cmd == ssf_pkg::CMD_QUAD_PROGRAM);
            ssf_pkg::MEM_FAMILY_B,
            ssf_pkg::MEM_FAMILY_D: family_ok = (cmd == ssf_pkg::CMD_FAMILY_EXTRA);
            default: family_ok = 1'b0;
        endcase
    end

    assign supported = common_ok | family_ok;

endmodule : ssf_cmd_check

//--- src/ssf_status_word.sv
`timescale 1ns/10ps
module ssf_status_word #(
    parameter logic [1:0] CORE_MODE = ssf_pkg::MODE_QUAD,
    parameter logic [1:0] MEM_FAMILY = ssf_pkg::MEM_FAMILY_A
) (
    input wire logic clock,
    input wire logic rstn,
    // Register port (AXI4-Lite subset of the AXI4 register interface)
    input wire logic [ssf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ssf_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ssf_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Control word fields, from the control register on this clock
    input wire ssf_pkg::ssf_ctrl_t control_word,
    // Transmit data queue write strobe and its data
    input wire logic txq_wr_valid,
    input wire logic [7:0] txq_wr_data,
    // Present error flags and one-cycle rise events for the interrupt status
    output ssf_pkg::ssf_flags_t err_flags,
    output ssf_pkg::ssf_flags_t err_events
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [ssf_pkg::DATA_W-1:0] rdata;
        ssf_pkg::ssf_flags_t flags;
        ssf_pkg::ssf_flags_t events;
        logic first_seen;
    } ssf_state_t;

    localparam ssf_state_t STATE_RESET = '{
        awready: 1'b0,
        wready: 1'b0,
        bvalid: 1'b0,
        bresp: ssf_pkg::RESP_OKAY,
        arready: 1'b0,
        rvalid: 1'b0,
        rresp: ssf_pkg::RESP_OKAY,
        rdata: '0,
        flags: ssf_pkg::FLAGS_RESET,
        events: '0,
        first_seen: 1'b0
    };

    ssf_state_t state_reg;
    ssf_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration checks

    localparam logic MULTI_LINE = (CORE_MODE == ssf_pkg::MODE_DUAL) ||
                                  (CORE_MODE == ssf_pkg::MODE_QUAD);

    logic cmd_supported;
    logic phase_not_single;
    logic mixed_clock;
    logic [ssf_pkg::DATA_W-1:0] status_image;

    ssf_cmd_check u_cmd_check (
        .mem_family(MEM_FAMILY),
        .cmd(txq_wr_data),
        .supported(cmd_supported)
    );

    assign phase_not_single = (control_word.cmd_lines != ssf_pkg::LINES_SINGLE) ||
                              (control_word.addr_lines != ssf_pkg::LINES_SINGLE) ||
                              (control_word.data_lines != ssf_pkg::LINES_SINGLE);
    assign mixed_clock = control_word.clk_polarity ^ control_word.clk_phase;

    // Reserved bits above the flags and the lower status bits read as zero
    always_comb begin
        status_image = '0;
        status_image[ssf_pkg::FLAG_MSB:ssf_pkg::FLAG_LSB] = state_reg.flags;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    logic wr_take;
    logic rd_take;
    logic wr_hit;
    logic rd_hit;

    assign wr_hit = (s_axi_awaddr[ssf_pkg::ADDR_W-1:2] ==
                     ssf_pkg::STATUS_WORD_OFFSET[ssf_pkg::ADDR_W-1:2]);
    assign rd_hit = (s_axi_araddr[ssf_pkg::ADDR_W-1:2] ==
                     ssf_pkg::STATUS_WORD_OFFSET[ssf_pkg::ADDR_W-1:2]);
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !state_reg.awready &&
                     !state_reg.bvalid;
    assign rd_take = s_axi_arvalid && !state_reg.arready && !state_reg.rvalid;

    always_comb begin
        state_next = state_reg;

        // Write channel: address and data taken together, then one answer.
        // Write data and strobes are ignored because the word is read-only.
        state_next.awready = 1'b0;
        state_next.wready = 1'b0;
        if (wr_take) begin
            state_next.awready = 1'b1;
            state_next.wready = 1'b1;
            state_next.bresp = wr_hit ? ssf_pkg::RESP_OKAY : ssf_pkg::RESP_SLVERR;
        end else if (state_reg.awready) begin
            state_next.bvalid = 1'b1;
        end else if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Read channel: data is sampled in the cycle the address is taken
        state_next.arready = 1'b0;
        if (rd_take) begin
            state_next.arready = 1'b1;
            if (rd_hit) begin
                state_next.rdata = status_image;
                state_next.rresp = ssf_pkg::RESP_OKAY;
            end else begin
                state_next.rdata = '0;
                state_next.rresp = ssf_pkg::RESP_SLVERR;
            end
        end else if (state_reg.arready) begin
            state_next.rvalid = 1'b1;
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        // Command mismatch is judged once, on the first queue write, and held
        if (txq_wr_valid && !state_reg.first_seen) begin
            state_next.first_seen = 1'b1;
            if (MULTI_LINE && !cmd_supported) begin
                state_next.flags.cmd_err = 1'b1;
            end
        end

        // Level flags follow the control word every clock
        state_next.flags.loop_err = control_word.loop_back && phase_not_single;
        state_next.flags.msb_err = MULTI_LINE && control_word.lsb_first;
        state_next.flags.role_err = MULTI_LINE && !control_word.controller_role;
        state_next.flags.clk_err = MULTI_LINE && mixed_clock;

        // A flag going high is reported once to the interrupt status logic
        state_next.events = state_next.flags & ~state_reg.flags;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rresp = state_reg.rresp;
    assign s_axi_rdata = state_reg.rdata;
    assign err_flags = state_reg.flags;
    assign err_events = state_reg.events;

endmodule : ssf_status_word

//--- tb/ssf_status_word_sva.sv
`timescale 1ns/10ps
module ssf_status_word_sva #(
    parameter logic [1:0] CORE_MODE = ssf_pkg::MODE_QUAD
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ssf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ssf_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire ssf_pkg::ssf_ctrl_t control_word,
    input wire ssf_pkg::ssf_flags_t err_flags,
    input wire ssf_pkg::ssf_flags_t err_events
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic dq;
    logic lines_used;
    logic [5:0] aw_word;
    assign dq = (CORE_MODE != ssf_pkg::MODE_STANDARD);
    assign lines_used = |{control_word.cmd_lines, control_word.addr_lines, control_word.data_lines};
    assign aw_word = s_axi_awaddr[7:2];
    ////////////////////////////////////////////////////////////
    rd_reserved_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:11] == 21'h0
        && s_axi_rdata[5:0] == 6'h0) else $error("reserved status bits set");
    rd_timing_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready ##1 s_axi_rvalid) else $error("read answer late");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
        |=> s_axi_awready ##1 (s_axi_bvalid && s_axi_bresp == ($past(aw_word, 2) ==
        ssf_pkg::STATUS_WORD_OFFSET[7:2] ? ssf_pkg::RESP_OKAY : ssf_pkg::RESP_SLVERR)))
        else $error("write response wrong");
    loop_flag_a: assert property ($past(rstn) |-> err_flags.loop_err ==
        ($past(control_word.loop_back) && $past(lines_used))) else $error("loop flag wrong");
    msb_flag_a: assert property ($past(rstn) |-> err_flags.msb_err ==
        (dq && $past(control_word.lsb_first))) else $error("bit order flag wrong");
    role_set_a: assert property ($past(rstn) && !$past(control_word.controller_role)
        |-> err_flags.role_err == dq) else $error("role flag not set");
    role_clear_a: assert property (control_word.controller_role |=> !err_flags.role_err)
        else $error("role flag not cleared");
    clk_flag_a: assert property ($past(rstn) |-> err_flags.clk_err == (dq &&
        ($past(control_word.clk_polarity) ^ $past(control_word.clk_phase))))
        else $error("clock format flag wrong");
    cmd_sticky_a: assert property (err_flags.cmd_err |=> err_flags.cmd_err)
        else $error("command flag dropped");
    flag_event_a: assert property ($past(rstn, 2) |-> err_events ==
        (err_flags & ~$past(err_flags))) else $error("flag event wrong");
endmodule : ssf_status_word_sva
bind ssf_status_word ssf_status_word_sva #(.CORE_MODE(CORE_MODE)) chk_u (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .control_word(control_word),
    .err_flags(err_flags), .err_events(err_events));

//--- tb/ssf_status_word_bench.sv
`timescale 1ns/10ps
module ssf_status_word_bench;
    logic clock = 1'b0, rstn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, txq_wr_data = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, txq_wr_valid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ssf_pkg::ssf_ctrl_t control_word = '0;
    ssf_pkg::ssf_flags_t err_flags, err_events, std_flags;
    int n_mismatch = 0, compares = 0, cycles = 0;
    ssf_status_word dut_u (.clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'b1), .control_word(control_word), .txq_wr_valid(txq_wr_valid),
        .txq_wr_data(txq_wr_data), .err_flags(err_flags), .err_events(err_events));
    // Single-line build on the same inputs: the dual/quad-only flags must never rise here
    ssf_status_word #(.CORE_MODE(ssf_pkg::MODE_STANDARD)) dut_std_u (.clock(clock), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b1),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
        .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b1),
        .control_word(control_word), .txq_wr_valid(txq_wr_valid), .txq_wr_data(txq_wr_data),
        .err_flags(std_flags), .err_events());
    initial forever #4 clock = ~clock;
    // Whole run is about a hundred cycles; the ceiling only catches a lost handshake
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Mismatches %0d of %0d compares", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Answers are read at the falling edge, the request drops at the next rising edge
    task automatic look(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge clock); while (s_axi_arready !== 1'b1);
        @(posedge clock);
        s_axi_arvalid <= 1'b0;
        do @(negedge clock); while (s_axi_rvalid !== 1'b1);
        check("rdata", e, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : look
    task automatic poke(input logic [7:0] a, input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'hFFFFFFFF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(negedge clock); while (s_axi_awready !== 1'b1);
        @(posedge clock);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge clock); while (s_axi_bvalid !== 1'b1);
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : poke
    task automatic push(input logic [7:0] b);
        @(posedge clock);
        txq_wr_valid <= 1'b1;
        txq_wr_data <= b;
        @(posedge clock);
        txq_wr_valid <= 1'b0;
    endtask : push
    function automatic logic [31:0] model(input logic cmd);
        logic [31:0] e;
        e = 32'h0;
        e[10] = cmd;
        e[9] = control_word.loop_back &
               (|{control_word.cmd_lines, control_word.addr_lines, control_word.data_lines});
        e[8] = control_word.lsb_first;
        e[7] = ~control_word.controller_role;
        e[6] = control_word.clk_polarity ^ control_word.clk_phase;
        return e;
    endfunction : model
    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
    endtask : do_reset
    ////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        look(8'h64, 32'h00000080, ssf_pkg::RESP_OKAY);
        check("err_flags", 32'h00000002, {27'h0, err_flags});
        check("std_flags", 32'h00000000, {27'h0, std_flags});
        push(8'h03);
        push(8'hAA);
        look(8'h64, 32'h00000080, ssf_pkg::RESP_OKAY);
        @(posedge clock) control_word.controller_role <= 1'b1;
        look(8'h64, 32'h00000000, ssf_pkg::RESP_OKAY);
        @(posedge clock) control_word.loop_back <= 1'b1;
        look(8'h64, 32'h00000000, ssf_pkg::RESP_OKAY);
        @(posedge clock) control_word.data_lines <= 2'h1;
        // The rise pulse stands for one cycle, in the same cycle that the flag first reads high
        @(negedge clock);
        @(negedge clock);
        check("err_events", 32'h00000008, {27'h0, err_events});
        look(8'h64, 32'h00000200, ssf_pkg::RESP_OKAY);
        @(posedge clock) control_word.loop_back <= 1'b0;
        look(8'h64, 32'h00000000, ssf_pkg::RESP_OKAY);
        @(posedge clock) control_word.lsb_first <= 1'b1;
        look(8'h64, 32'h00000100, ssf_pkg::RESP_OKAY);
        check("std_flags", 32'h00000000, {27'h0, std_flags});
        @(posedge clock) control_word.lsb_first <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock) {control_word.clk_polarity, control_word.clk_phase} <= i[1:0];
            look(8'h64, {25'h0, i[1] ^ i[0], 6'h0}, ssf_pkg::RESP_OKAY);
        end
        poke(8'h64, ssf_pkg::RESP_OKAY);
        look(8'h64, model(1'b0), ssf_pkg::RESP_OKAY);
        poke(8'h10, ssf_pkg::RESP_SLVERR);
        look(8'h10, 32'h00000000, ssf_pkg::RESP_SLVERR);
        do_reset();
        push(8'hAA);
        look(8'h64, model(1'b1), ssf_pkg::RESP_OKAY);
        push(8'h03);
        look(8'h64, model(1'b1), ssf_pkg::RESP_OKAY);
        check("std_flags", 32'h00000000, {27'h0, std_flags});
        report_and_stop();
    end
endmodule : ssf_status_word_bench
